// ---- design/adc_control_registers.sv ----
// Register file and sequencing for a shared 12-bit converter.
// Assumes the analog core answers on clk_sys with a one-cycle done pulse and result.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module adc_control_registers #(
    parameter int NUM_PINS = `NUM_EXT_CHANNELS
) (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic [2:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [7:0]                       reg_rdata,
    output adc_ctrl_pkg::core_req_type       core_req,
    input  wire adc_ctrl_pkg::core_rsp_type  core_rsp,
    output logic                             conv_clk_en,
    output logic [NUM_PINS-1:0]              analog_pin_sel,
    output logic                             irq
);
    import adc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONVERT
    } conv_state_type;

    conv_state_type state_r;
    conv_state_type state_nxt;
    logic [7:0]     ctl_primary_r;
    logic [7:0]     ctl_second_r;
    logic [7:0]     res_low_r;
    logic [7:0]     res_high_r;
    logic           irq_status_r;
    logic           irq_mask_r;
    logic [6:0]     div_cnt_r;
    logic           start_prev_r;
    logic [7:0]     rdata_r;
    core_req_type   req_r;
    logic           clk_en_r;
    logic [NUM_PINS-1:0] pin_sel_r;
    logic           irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    wire logic       wr_primary   = reg_wr && (reg_addr == `ADR_CONTROL_PRIMARY);
    wire logic       wr_second    = reg_wr && (reg_addr == `ADR_CONTROL_SECOND);
    wire logic       wr_status    = reg_wr && (reg_addr == `ADR_IRQ_STATUS);
    wire logic       wr_mask      = reg_wr && (reg_addr == `ADR_IRQ_MASK);
    wire logic       start_bit    = ctl_primary_r[`BIT_START];
    wire logic       enable_bit   = ctl_primary_r[`BIT_ENABLE];
    wire logic       align_bit    = ctl_primary_r[`BIT_ALIGN];
    wire logic [3:0] ext_sel      = ctl_primary_r[3:0];
    wire logic [2:0] src_sel      = ctl_second_r[7:5];
    wire logic [2:0] clk_sel      = ctl_second_r[2:0];
    wire logic       start_fall   = start_prev_r && !start_bit;
    wire logic       busy         = (state_r == ST_CONVERT);
    wire logic       core_done    = busy && core_rsp.done && enable_bit;
    wire logic [11:0] res         = core_rsp.result;

    // Busy bit comes from the sequencer, never from the written byte
    wire logic [7:0] primary_wr_val = {reg_wdata[7], 1'b0, reg_wdata[5:0]};
    wire logic [7:0] primary_view   = {ctl_primary_r[7], busy, ctl_primary_r[5:0]};

    // Result packing per alignment; unused positions are zero
    wire logic [7:0] pack_high = align_bit ? {4'h0, res[11:8]} : res[11:4];
    wire logic [7:0] pack_low  = align_bit ? res[7:0] : {res[3:0], 4'h0};

    // Input multiplexer: one source reaches the single converter
    wire logic       src_bg    = (src_sel == `SRC_BANDGAP);
    wire logic       src_oc    = (src_sel == `SRC_OVERCURRENT);
    wire logic       src_gnd   = (src_sel == `SRC_GROUND_A) || (src_sel == `SRC_GROUND_B);
    wire mux_source_type mux_sel = src_bg ? MUX_BANDGAP :
                                   src_oc ? MUX_OVERCURRENT :
                                   src_gnd ? MUX_GROUND : MUX_EXTERNAL;
    wire logic       ext_ok    = (mux_sel == MUX_EXTERNAL) && !ext_sel[3];

    // Divider terminal count: divide by 2^clk_sel
    wire logic [6:0] div_mask  = 7'((8'h01 << clk_sel) - 8'h01);
    wire logic       div_tick  = ((div_cnt_r & div_mask) == div_mask);

    // Read mux, unmapped addresses read zero
    logic [7:0] rdata_nxt;
    always_comb begin
        case (reg_addr)
            `ADR_RESULT_LOW:      rdata_nxt = res_low_r;
            `ADR_RESULT_HIGH:     rdata_nxt = res_high_r;
            `ADR_CONTROL_PRIMARY: rdata_nxt = primary_view;
            `ADR_CONTROL_SECOND:  rdata_nxt = ctl_second_r;
            `ADR_IRQ_STATUS:      rdata_nxt = {7'h00, irq_status_r};
            `ADR_IRQ_MASK:        rdata_nxt = {7'h00, irq_mask_r};
            default:              rdata_nxt = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_bit) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (start_fall && enable_bit) begin
                    state_nxt = ST_CONVERT;
                end else if (!start_bit) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CONVERT: begin
                if (start_bit) begin
                    state_nxt = ST_ARMED;
                end else if (core_done || !enable_bit) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Registers and sequencer state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r       <= ST_IDLE;
            ctl_primary_r <= `RST_CONTROL_PRIMARY;
            ctl_second_r  <= `RST_CONTROL_SECOND;
            start_prev_r  <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            start_prev_r <= start_bit;
            if (wr_primary) begin
                ctl_primary_r <= primary_wr_val;
            end
            if (wr_second) begin
                ctl_second_r <= reg_wdata;
            end
        end
    end

    // Result capture in the completion cycle, held while disabled
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            res_low_r  <= `RST_RESULT;
            res_high_r <= `RST_RESULT;
        end else if (core_done) begin
            res_low_r  <= pack_low;
            res_high_r <= pack_high;
        end
    end

    // Completion interrupt: set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_status_r <= 1'b0;
            irq_mask_r   <= 1'b0;
        end else begin
            irq_status_r <= core_done || (irq_status_r && !(wr_status && reg_wdata[0]));
            if (wr_mask) begin
                irq_mask_r <= reg_wdata[0];
            end
        end
    end

    // Conversion clock divider, restarted while held in reset
    always_ff @(posedge clk_sys) begin
        if (srst || start_bit || !enable_bit) begin
            div_cnt_r <= 7'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output flops

    core_req_type req_nxt;
    always_comb begin
        req_nxt.power_on      = enable_bit;
        req_nxt.hold_reset    = start_bit;
        req_nxt.start         = (state_r == ST_ARMED) && (state_nxt == ST_CONVERT);
        req_nxt.clock_divider = clk_sel;
        req_nxt.source        = mux_sel;
        req_nxt.ext_valid     = ext_ok;
        req_nxt.ext_channel   = ext_sel[2:0];
    end

    // Pin ownership: a selected analog pin drops its digital role and pull-high
    logic [NUM_PINS-1:0] pin_sel_nxt;
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            assign pin_sel_nxt[g] = enable_bit && ext_ok && (ext_sel[2:0] == 3'(g));
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_r   <= 8'h00;
            req_r     <= '0;
            clk_en_r  <= 1'b0;
            pin_sel_r <= '0;
            irq_r     <= 1'b0;
        end else begin
            rdata_r   <= reg_rd ? rdata_nxt : 8'h00;
            req_r     <= req_nxt;
            clk_en_r  <= div_tick && enable_bit && !start_bit;
            pin_sel_r <= pin_sel_nxt;
            irq_r     <= (irq_status_r && irq_mask_r) || (core_done && irq_mask_r);
        end
    end

    assign reg_rdata      = rdata_r;
    assign core_req       = req_r;
    assign conv_clk_en    = clk_en_r;
    assign analog_pin_sel = pin_sel_r;
    assign irq            = irq_r;

endmodule

// ---- design/adc_ctrl_params.svh ----
// Offsets, field positions, reset values, source codes and channel count of the converter control block.
// Assumes a byte-wide register port; each register sits at its own index.
// Summary of operation
// - Alignment 0: bits 11..4 high, 3..0 low-top
// - Alignment 1: bits 11..8 high-low, 7..0 low
// - Unused result bit positions read zero
// - Disabled converter keeps result registers unchanged
// - Start bit high then low starts conversion
// - Start bit high holds conversion in reset
// - Busy set on start, cleared on completion
// - Busy bit read-only, writes ignored
// - Enable bit powers converter on or off
// - Channel codes 8..15 connect nothing
// - Source field picks external or internal signal
// - 001 bandgap, 010 overcurrent, 011/100 ground
// - Analog pin loses digital function and pull-high
// - One converter, one source at a time
// - Clock field divides system clock 1..128
// - Completion raises converter interrupt request
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define ADR_RESULT_LOW      3'h0
`define ADR_RESULT_HIGH     3'h1
`define ADR_CONTROL_PRIMARY 3'h2
`define ADR_CONTROL_SECOND  3'h3
`define ADR_IRQ_STATUS      3'h4
`define ADR_IRQ_MASK        3'h5

`define BIT_START           7
`define BIT_BUSY            6
`define BIT_ENABLE          5
`define BIT_ALIGN           4

`define RST_CONTROL_PRIMARY 8'h00
`define RST_CONTROL_SECOND  8'h00
`define RST_RESULT          8'h00
`define RST_IRQ             8'h00

`define SRC_BANDGAP         3'h1
`define SRC_OVERCURRENT     3'h2
`define SRC_GROUND_A        3'h3
`define SRC_GROUND_B        3'h4

`define NUM_EXT_CHANNELS    8

`endif

// ---- design/adc_ctrl_pkg.sv ----
// Types shared by the converter control block.
// Assumes the params header is included by users that need constants.
package adc_ctrl_pkg;

    // Selection of the converter input multiplexer
    typedef enum logic [1:0] {
        MUX_EXTERNAL,
        MUX_BANDGAP,
        MUX_OVERCURRENT,
        MUX_GROUND
    } mux_source_type;

    // Request from the control logic to the analog core
    typedef struct packed {
        logic           power_on;
        logic           hold_reset;
        logic           start;
        logic [2:0]     clock_divider;
        mux_source_type source;
        logic           ext_valid;
        logic [2:0]     ext_channel;
    } core_req_type;

    // Answer from the analog core
    typedef struct packed {
        logic        done;
        logic [11:0] result;
    } core_rsp_type;

endpackage

// ---- test/adc_control_registers_tb.sv ----
// Self-checking bench for the converter control block.
// Assumes a 100 MHz clock and the core model on the far side.
`timescale 1ns/100ps
module adc_control_registers_tb;
    import adc_ctrl_pkg::*;
    logic         clk_sys   = 1'b0;
    logic         srst      = 1'b1;
    logic [2:0]   reg_addr  = 3'h0;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic [7:0]   reg_rdata;
    core_req_type core_req;
    core_rsp_type core_rsp;
    logic         conv_clk_en;
    logic [7:0]   pin_sel;
    logic         irq;
    logic [11:0]  sample    = 12'h000;
    logic [7:0]   lat       = 8'h08;
    int           err_total = 0;
    int           cmp_count = 0;
    int           cyc       = 0;
    int           n;
    int           c;
    always #5 clk_sys = ~clk_sys;
    adc_control_registers #(.NUM_PINS(8)) u_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req),
        .core_rsp(core_rsp), .conv_clk_en(conv_clk_en), .analog_pin_sel(pin_sel), .irq(irq));
    adc_core_model u_core (.clk_sys(clk_sys), .srst(srst), .core_req(core_req), .sample(sample), .lat(lat),
        .core_rsp(core_rsp));
    ////////////////////////////////////////////////////////////////////////
    // Compare, bus access, clock-enable wait, conversion and closing tasks
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic gap();
        c = 0;
        do begin
            @(posedge clk_sys);
            #1 c++;
        end while (conv_clk_en !== 1'b1 && c < 300);
    endtask
    task automatic conv(input logic [7:0] ctl, input logic [11:0] val);
        sample <= val;
        wr(3'h2, ctl | 8'h80);
        rdc(3'h2, ctl | 8'h80);
        wr(3'h2, ctl);
        rdc(3'h2, ctl | 8'h40);
        c = 0;
        while (core_rsp.done !== 1'b1 && c < 300) begin
            @(posedge clk_sys);
            #1 c++;
        end
        chk(c < 300, 1'b1);
        rdc(3'h2, ctl);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        for (n = 0; n < 8; n++) rdc(n[2:0], 8'h00);
        wr(3'h2, 8'hFF);
        rdc(3'h2, 8'hBF);
        chk(core_req.hold_reset, 1'b1);
        for (n = 0; n < 8; n++) begin
            wr(3'h3, {n[2:0], 5'h02});
            rdc(3'h3, {n[2:0], 5'h02});
            chk(core_req.source, n == 1 ? MUX_BANDGAP : n == 2 ? MUX_OVERCURRENT :
                (n == 3 || n == 4) ? MUX_GROUND : MUX_EXTERNAL);
            chk(core_req.clock_divider, 3'h2);
        end
        wr(3'h2, 8'h00);
        rdc(3'h2, 8'h00);
        for (n = 0; n < 16; n++) begin
            wr(3'h2, 8'h20 | n[3:0]);
            rdc(3'h2, 8'h20 | n[3:0]);
            chk(pin_sel, n < 8 ? 8'h01 << n : 8'h00);
            chk(core_req.ext_valid, n < 8);
        end
        for (n = 0; n < 8; n += 3) begin
            wr(3'h3, n[7:0]);
            gap();
            gap();
            gap();
            chk(c, 1 << n);
        end
        wr(3'h5, 8'h00);
        conv(8'h23, 12'hABC);
        chk(pin_sel, 8'h08);
        rdc(3'h0, 8'hC0);
        rdc(3'h1, 8'hAB);
        rdc(3'h4, 8'h01);
        chk(irq, 1'b0);
        wr(3'h5, 8'h01);
        rdc(3'h5, 8'h01);
        chk(irq, 1'b1);
        wr(3'h4, 8'h01);
        rdc(3'h4, 8'h00);
        chk(irq, 1'b0);
        lat <= 8'h28;
        conv(8'h30, 12'h5A3);
        rdc(3'h1, 8'h05);
        rdc(3'h0, 8'hA3);
        chk(irq, 1'b1);
        wr(3'h2, 8'h90);
        wr(3'h2, 8'h10);
        rdc(3'h2, 8'h10);
        rdc(3'h1, 8'h05);
        rdc(3'h0, 8'hA3);
        test_done();
    end
endmodule

// ---- test/adc_core_model.sv ----
// Behavioural analog core: one conversion at a time, done after lat cycles.
// Assumes clk_sys domain; result stands only in the done cycle.
`timescale 1ns/100ps
module adc_core_model (
    input  wire logic                       clk_sys,
    input  wire logic                       srst,
    input  wire adc_ctrl_pkg::core_req_type core_req,
    input  wire logic [11:0]                sample,
    input  wire logic [7:0]                 lat,
    output adc_ctrl_pkg::core_rsp_type      core_rsp
);
    import adc_ctrl_pkg::*;
    logic [7:0]  left_r;
    logic [11:0] last_r = 12'h5A5;
    // Count down from the start pulse; off-cycle result is garbage
    always_ff @(posedge clk_sys) begin
        core_rsp.done <= 1'b0;
        core_rsp.result <= ~last_r;
        if (srst || core_req.hold_reset || !core_req.power_on) begin
            left_r <= 8'h00;
        end else if (core_req.start) begin
            left_r <= lat;
        end else if (left_r == 8'h01) begin
            left_r <= 8'h00;
            core_rsp.done <= 1'b1;
            core_rsp.result <= sample;
            last_r <= sample;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
endmodule

// ---- test/adc_ctrl_sva.sv ----
// Port assertions for the converter control block.
// Assumes one clock domain with synchronous reset; bound below.
`timescale 1ns/100ps
module adc_ctrl_chk #(
    parameter int NUM_PINS = 8
) (
    input wire logic                       clk_sys,
    input wire logic                       srst,
    input wire logic [2:0]                 reg_addr,
    input wire logic [7:0]                 reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [7:0]                 reg_rdata,
    input wire adc_ctrl_pkg::core_req_type core_req,
    input wire adc_ctrl_pkg::core_rsp_type core_rsp,
    input wire logic                       conv_clk_en,
    input wire logic [NUM_PINS-1:0]        analog_pin_sel,
    input wire logic                       irq
);
    import adc_ctrl_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    // Read port, start sequencing, routing and interrupt causes
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_start_held: assert property (core_req.hold_reset |-> !core_req.start)
        else $error("start while held");
    a_start_pulse: assert property (core_req.start |=> !core_req.start)
        else $error("start pulse too long");
    a_start_power: assert property (core_req.start |-> core_req.power_on)
        else $error("start while powered off");
    a_pin_onehot: assert property ($onehot0(analog_pin_sel))
        else $error("several pins selected");
    a_pin_route: assert property (|analog_pin_sel |-> core_req.ext_valid && analog_pin_sel[core_req.ext_channel])
        else $error("pin select disagrees with channel");
    a_ext_source: assert property (core_req.ext_valid |-> core_req.source == MUX_EXTERNAL)
        else $error("external valid with internal source");
    a_clk_gate: assert property (conv_clk_en |-> core_req.power_on && !core_req.hold_reset)
        else $error("conversion clock while idle");
    a_done_irq: assert property ($rose(irq) |-> $past(core_rsp.done) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt without cause");
    // Main scenarios reached
    cover property (core_req.start);
    cover property ($rose(irq));
    cover property (|analog_pin_sel);
endmodule
bind adc_control_registers adc_ctrl_chk #(.NUM_PINS(NUM_PINS)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req), .core_rsp(core_rsp),
    .conv_clk_en(conv_clk_en), .analog_pin_sel(analog_pin_sel), .irq(irq)
);
